/* File: rtl/arith_defs.vh */
`ifndef ARITH_DEFS_VH
`define ARITH_DEFS_VH

// register byte offsets
`define REG_OPA         8'h00
`define REG_OPB         8'h04
`define REG_ACC         8'h08
`define REG_EXT         8'h0C
`define REG_FLAGS       8'h10
`define REG_CTRL        8'h14
`define REG_STATUS      8'h18

// reset values
`define RST_WORD        32'h00000000
`define RST_FLAGS       12'h000

// flag bit positions
`define FL_CY           0
`define FL_PA           2
`define FL_HC           4
`define FL_ZR           6
`define FL_SG           7
`define FL_OV           11
`define FL_MASK         12'h8D5

// control word fields
`define CTRL_OP_HI      4
`define CTRL_OP_LO      0
`define CTRL_W_HI       9
`define CTRL_W_LO       8
`define CTRL_SRCW       12
`define STAT_ERR        31

// operand widths
`define W_8             2'h0
`define W_16            2'h1
`define W_32            2'h2

// operation codes
`define OP_ADD          5'h00
`define OP_ADC          5'h01
`define OP_SUB          5'h02
`define OP_SUBB         5'h03
`define OP_INC          5'h04
`define OP_DCR          5'h05
`define OP_COMP         5'h06
`define OP_FLIP         5'h07
`define OP_UMUL         5'h08
`define OP_SMUL         5'h09
`define OP_SMULT        5'h0A
`define OP_DIV          5'h0B
`define OP_SDIV         5'h0C
`define OP_PSUM         5'h0D
`define OP_PDIF         5'h0E
`define OP_USUM         5'h0F
`define OP_UDIF         5'h10
`define OP_UPRD         5'h11
`define OP_UQUO         5'h12
`define OP_CBW          5'h13
`define OP_WSX          5'h14
`define OP_DSX          5'h15
`define OP_SEXT         5'h16
`define OP_ZEXT         5'h17

// decimal base and bus answers
`define DEC_BASE        8'h0A
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: rtl/integer_bcd_arith_unit.v */
// Contract
// - word_sign_spread fills extend_word_reg with bit 15 of accum_word.
// - dword_sign_spread fills extend_dword_reg with bit 31 of accum_dword.
// - move_sign_extend widens 8 to 16, or 8/16 to 32, copying the sign.
// - move_zero_extend widens 8 to 16, or 8/16 to 32, filling zeros.
// - arithmetic works on 8, 16 and 32 bit signed or unsigned operands.
// - sum with carry in adds carry_flag; plain sum never does.
// - difference with borrow in subtracts carry_flag; plain difference never does.
// - plus one and minus one add or subtract one from one operand.
// - compare updates the six flags from the difference, stores nothing.
// - sign flip writes zero minus the operand.
// - unsigned product gives a result twice the source width.
// - signed product is double width, or truncated to source width in one form.
// - unsigned quotient gives quotient and remainder.
// - signed quotient is the same but signed.
// - packed fix after sum makes two packed digits, carry_flag on decimal carry.
// - packed fix after difference makes two packed digits, carry_flag on borrow.
// - unpacked fix after sum keeps low digit, carry bumps accum_high_byte.
// - unpacked fix after difference keeps low digit, borrow drops accum_high_byte.
// - unpacked fix after product splits accum_low_byte into two unpacked digits.
// - unpacked fix before quotient merges two digits into accum_low_byte.
// - byte sign spread copies bit 7 of accum_low_byte into accum_high_byte.
`timescale 1ns/1ps
`include "arith_defs.vh"
`default_nettype none

module integer_bcd_arith_unit (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // write address channel
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    // write data channel
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    // write response channel
    output wire [1:0]  bresp,
    output wire        bvalid,
    input  wire        bready,
    // read address channel
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    // read data channel
    output wire [31:0] rdata,
    output wire [1:0]  rresp,
    output wire        rvalid,
    input  wire        rready
);

    function [31:0] wmask;
        input [1:0] w;
        begin
            if (w == `W_8) wmask = 32'h000000FF;
            else if (w == `W_16) wmask = 32'h0000FFFF;
            else wmask = 32'hFFFFFFFF;
        end
    endfunction

    function sign_of;
        input [31:0] v;
        input [1:0]  w;
        begin
            if (w == `W_8) sign_of = v[7];
            else if (w == `W_16) sign_of = v[15];
            else sign_of = v[31];
        end
    endfunction

    function [31:0] sext;
        input [31:0] v;
        input [1:0]  w;
        begin
            if (w == `W_8) sext = {{24{v[7]}}, v[7:0]};
            else if (w == `W_16) sext = {{16{v[15]}}, v[15:0]};
            else sext = v;
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // packs the six status flags, sign/zero/parity taken from r
    function [11:0] pack;
        input [31:0] r;
        input [1:0]  w;
        input        cy;
        input        hc;
        input        ov;
        begin
            pack = `RST_FLAGS;
            pack[`FL_CY] = cy;
            pack[`FL_PA] = ~^r[7:0];
            pack[`FL_HC] = hc;
            pack[`FL_ZR] = ((r & wmask(w)) == 32'h00000000);
            pack[`FL_SG] = sign_of(r, w);
            pack[`FL_OV] = ov;
        end
    endfunction

    // architectural state
    reg  [31:0] opa_ff;
    reg  [31:0] opb_ff;
    reg  [31:0] acc_ff;
    reg  [31:0] ext_ff;
    reg  [11:0] flags_ff;
    reg  [31:0] ctrl_ff;
    reg         err_ff;

    // bus slave state
    reg         aw_held_ff;
    reg         w_held_ff;
    reg  [7:0]  awaddr_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         bvalid_ff;
    reg  [1:0]  bresp_ff;
    reg         rvalid_ff;
    reg  [31:0] rdata_ff;
    reg  [1:0]  rresp_ff;

    assign awready = !aw_held_ff && !bvalid_ff;
    assign wready  = !w_held_ff && !bvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = !rvalid_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;

    wire        aw_have = aw_held_ff || (awvalid && awready);
    wire        w_have  = w_held_ff || (wvalid && wready);
    wire        do_wr   = aw_have && w_have;
    wire [7:0]  wr_addr = aw_held_ff ? awaddr_ff : awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : wdata;
    wire [3:0]  wr_strb = w_held_ff ? wstrb_ff : wstrb;
    wire        wr_ok   = (wr_addr[1:0] == 2'h0) && (wr_addr <= `REG_STATUS);
    wire        wr_ctrl = do_wr && (wr_addr == `REG_CTRL);
    wire [31:0] fl_wr   = merge({20'h0, flags_ff}, wr_data, wr_strb);

    // operation decode from the control word being written
    wire [31:0] cw   = merge(ctrl_ff, wr_data, wr_strb);
    wire [4:0]  op   = cw[`CTRL_OP_HI:`CTRL_OP_LO];
    wire [1:0]  w    = cw[`CTRL_W_HI:`CTRL_W_LO];
    wire        srcw = cw[`CTRL_SRCW];
    wire        cyf  = flags_ff[`FL_CY];
    wire        hcf  = flags_ff[`FL_HC];
    wire [31:0] m    = wmask(w);

    // shared adder/subtractor
    wire [31:0] a    = opa_ff & m;
    wire [31:0] b    = opb_ff & m;
    wire        one  = (op == `OP_INC) || (op == `OP_DCR);
    wire        cin  = ((op == `OP_ADC) || (op == `OP_SUBB)) && cyf;
    wire [31:0] x    = (op == `OP_FLIP) ? 32'h00000000 : a;
    wire [31:0] y    = one ? 32'h00000001 : ((op == `OP_FLIP) ? a : b);
    wire [32:0] s33  = {1'b0, x} + {1'b0, y} + {32'h00000000, cin};
    wire [32:0] d33  = {1'b0, x} - {1'b0, y} - {32'h00000000, cin};
    wire        is_add = (op == `OP_ADD) || (op == `OP_ADC) || (op == `OP_INC);
    wire [32:0] r33  = is_add ? s33 : d33;
    wire [31:0] r    = r33[31:0] & m;
    wire        co   = sign_of(r33[32:1], w);
    wire        sx   = sign_of(x, w);
    wire        sy   = sign_of(y, w);
    wire        sr   = sign_of(r, w);
    wire        ovf  = is_add ? ((sx == sy) && (sr != sx)) : ((sx != sy) && (sr != sx));
    wire        afr  = x[4] ^ y[4] ^ r[4];

    // multiplier on accumulator and operand b
    wire [31:0]        am   = acc_ff & m;
    wire [31:0]        sa32 = sext(am, w);
    wire [31:0]        sb32 = sext(b, w);
    wire signed [63:0] sam  = {{32{sa32[31]}}, sa32};
    wire signed [63:0] sbm  = {{32{sb32[31]}}, sb32};
    wire [63:0]        up   = {32'h00000000, am} * {32'h00000000, b};
    wire signed [63:0] sp   = sam * sbm;
    wire [31:0]        spl  = sext(sp[31:0], w);
    wire               sfit = (sp == {{32{spl[31]}}, spl});
    wire               ufit = ((up[63:0] & ~{32'h00000000, m}) == 64'h0);

    // divider, dividend sized by width
    reg  [63:0]        dvd;
    reg  signed [63:0] sdvd;
    always @* begin
        if (w == `W_8) begin
            dvd  = {48'h0, acc_ff[15:0]};
            sdvd = {{48{acc_ff[15]}}, acc_ff[15:0]};
        end else if (w == `W_16) begin
            dvd  = {32'h0, ext_ff[15:0], acc_ff[15:0]};
            sdvd = {{32{ext_ff[15]}}, ext_ff[15:0], acc_ff[15:0]};
        end else begin
            dvd  = {ext_ff, acc_ff};
            sdvd = {ext_ff, acc_ff};
        end
    end
    wire               dzero = (b == 32'h00000000);
    wire [63:0]        dv    = {32'h00000000, b};
    wire [63:0]        uq    = dzero ? 64'h0 : dvd / dv;
    wire [63:0]        ur    = dzero ? 64'h0 : dvd % dv;
    wire signed [63:0] sq    = dzero ? 64'sh0 : sdvd / sbm;
    wire signed [63:0] srm   = dzero ? 64'sh0 : sdvd % sbm;
    wire               idv   = (op == `OP_SDIV);
    wire [63:0]        q     = idv ? sq : uq;
    wire [63:0]        rm    = idv ? srm : ur;
    wire [31:0]        sql   = sext(q[31:0], w);
    wire               qbad  = idv ? (q != {{32{sql[31]}}, sql})
                                   : ((q & ~{32'h00000000, m}) != 64'h0);

    // decimal adjust helpers on accum_low_byte
    wire [7:0] lob    = acc_ff[7:0];
    wire [7:0] hib    = acc_ff[15:8];
    wire       lo_fx  = (lob[3:0] > 4'h9) || hcf;
    wire       hi_fx  = (lob > 8'h99) || cyf;
    wire [8:0] lob_p6 = {1'b0, lob} + 9'h006;
    wire [7:0] lob_q  = lob / `DEC_BASE;
    wire [7:0] lob_r  = lob % `DEC_BASE;
    wire [15:0] ad_w  = {8'h00, hib} * {8'h00, `DEC_BASE};
    wire [7:0] ad_v   = ad_w[7:0] + lob;

    reg  [31:0] nxt_opa;
    reg  [31:0] nxt_acc;
    reg  [31:0] nxt_ext;
    reg  [11:0] nxt_flags;
    reg         nxt_err;
    reg  [7:0]  t8;
    reg         tc;
    always @* begin
        nxt_opa   = opa_ff;
        nxt_acc   = acc_ff;
        nxt_ext   = ext_ff;
        nxt_flags = flags_ff;
        nxt_err   = 1'b0;
        t8        = lob;
        tc        = 1'b0;
        case (op)
            `OP_ADD, `OP_ADC, `OP_SUB, `OP_SUBB, `OP_FLIP: begin
                nxt_opa   = (opa_ff & ~m) | r;
                nxt_flags = pack(r, w, co, afr, ovf);
            end
            `OP_INC, `OP_DCR: begin
                nxt_opa   = (opa_ff & ~m) | r;
                nxt_flags = pack(r, w, cyf, afr, ovf);
            end
            `OP_COMP: begin
                nxt_flags = pack(r, w, co, afr, ovf);
            end
            `OP_UMUL: begin
                if (w == `W_8) nxt_acc[15:0] = up[15:0];
                else if (w == `W_16) begin
                    nxt_acc[15:0] = up[15:0];
                    nxt_ext[15:0] = up[31:16];
                end else begin
                    nxt_acc = up[31:0];
                    nxt_ext = up[63:32];
                end
                nxt_flags[`FL_CY] = !ufit;
                nxt_flags[`FL_OV] = !ufit;
            end
            `OP_SMUL: begin
                if (w == `W_8) nxt_acc[15:0] = sp[15:0];
                else if (w == `W_16) begin
                    nxt_acc[15:0] = sp[15:0];
                    nxt_ext[15:0] = sp[31:16];
                end else begin
                    nxt_acc = sp[31:0];
                    nxt_ext = sp[63:32];
                end
                nxt_flags[`FL_CY] = !sfit;
                nxt_flags[`FL_OV] = !sfit;
            end
            `OP_SMULT: begin
                nxt_opa = (opa_ff & ~m) | (sp[31:0] & m);
                nxt_flags[`FL_CY] = !sfit;
                nxt_flags[`FL_OV] = !sfit;
            end
            `OP_DIV, `OP_SDIV: begin
                // divide by zero or oversized quotient sets the error bit, leaves acc, ext and flags alone
                if (dzero || qbad) nxt_err = 1'b1;
                else if (w == `W_8) nxt_acc[15:0] = {rm[7:0], q[7:0]};
                else if (w == `W_16) begin
                    nxt_acc[15:0] = q[15:0];
                    nxt_ext[15:0] = rm[15:0];
                end else begin
                    nxt_acc = q[31:0];
                    nxt_ext = rm[31:0];
                end
            end
            `OP_PSUM: begin
                if (lo_fx) begin
                    t8 = lob_p6[7:0];
                    tc = cyf || lob_p6[8];
                end
                if (hi_fx) begin
                    t8 = t8 + 8'h60;
                    tc = 1'b1;
                end else tc = 1'b0;
                nxt_acc[7:0] = t8;
                nxt_flags = pack({24'h0, t8}, `W_8, tc, lo_fx, flags_ff[`FL_OV]);
            end
            `OP_PDIF: begin
                if (lo_fx) begin
                    t8 = lob - 8'h06;
                    tc = cyf || (lob < 8'h06);
                end
                if (hi_fx) begin
                    t8 = t8 - 8'h60;
                    tc = 1'b1;
                end else tc = 1'b0;
                nxt_acc[7:0] = t8;
                nxt_flags = pack({24'h0, t8}, `W_8, tc, lo_fx, flags_ff[`FL_OV]);
            end
            `OP_USUM, `OP_UDIF: begin
                if (lo_fx) begin
                    t8 = (op == `OP_USUM) ? lob_p6[7:0] : lob - 8'h06;
                    nxt_acc[15:8] = (op == `OP_USUM) ? hib + 8'h01 : hib - 8'h01;
                end
                nxt_acc[7:0] = {4'h0, t8[3:0]};
                nxt_flags[`FL_CY] = lo_fx;
                nxt_flags[`FL_HC] = lo_fx;
            end
            `OP_UPRD: begin
                nxt_acc[15:0] = {lob_q, lob_r};
                nxt_flags = pack({24'h0, lob_r}, `W_8, cyf, hcf, flags_ff[`FL_OV]);
            end
            `OP_UQUO: begin
                nxt_acc[15:0] = {8'h00, ad_v};
                nxt_flags = pack({24'h0, ad_v}, `W_8, cyf, hcf, flags_ff[`FL_OV]);
            end
            `OP_CBW: begin
                nxt_acc[15:8] = {8{acc_ff[7]}};
            end
            `OP_WSX: begin
                nxt_ext[15:0] = {16{acc_ff[15]}};
            end
            `OP_DSX: begin
                nxt_ext = {32{acc_ff[31]}};
            end
            `OP_SEXT: begin
                if (srcw) nxt_opa = (opa_ff & ~m) | (sext(opb_ff, `W_16) & m);
                else nxt_opa = (opa_ff & ~m) | (sext(opb_ff, `W_8) & m);
            end
            `OP_ZEXT: begin
                if (srcw) nxt_opa = (opa_ff & ~m) | {16'h0000, opb_ff[15:0]};
                else nxt_opa = (opa_ff & ~m) | {24'h000000, opb_ff[7:0]};
            end
            default: begin
                nxt_err = 1'b1;
            end
        endcase
    end

    // register file and write channel
    always @(posedge clock) begin
        if (rst) begin
            opa_ff     <= `RST_WORD;
            opb_ff     <= `RST_WORD;
            acc_ff     <= `RST_WORD;
            ext_ff     <= `RST_WORD;
            flags_ff   <= `RST_FLAGS;
            ctrl_ff    <= `RST_WORD;
            err_ff     <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= `RST_WORD;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            if (bvalid_ff && bready) bvalid_ff <= 1'b0;
            if (do_wr) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_addr == `REG_OPA) opa_ff <= merge(opa_ff, wr_data, wr_strb);
                else if (wr_addr == `REG_OPB) opb_ff <= merge(opb_ff, wr_data, wr_strb);
                else if (wr_addr == `REG_ACC) acc_ff <= merge(acc_ff, wr_data, wr_strb);
                else if (wr_addr == `REG_EXT) ext_ff <= merge(ext_ff, wr_data, wr_strb);
                else if (wr_addr == `REG_FLAGS)
                    flags_ff <= fl_wr[11:0] & `FL_MASK;
                else if (wr_ctrl) begin
                    ctrl_ff  <= cw;
                    opa_ff   <= nxt_opa;
                    acc_ff   <= nxt_acc;
                    ext_ff   <= nxt_ext;
                    flags_ff <= nxt_flags;
                    err_ff   <= nxt_err;
                end
            end else begin
                if (awvalid && awready) begin
                    aw_held_ff <= 1'b1;
                    awaddr_ff  <= awaddr;
                end
                if (wvalid && wready) begin
                    w_held_ff <= 1'b1;
                    wdata_ff  <= wdata;
                    wstrb_ff  <= wstrb;
                end
            end
        end
    end

    // read channel
    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_ok  = 1'b1;
        rd_val = `RST_WORD;
        if (araddr == `REG_OPA) rd_val = opa_ff;
        else if (araddr == `REG_OPB) rd_val = opb_ff;
        else if (araddr == `REG_ACC) rd_val = acc_ff;
        else if (araddr == `REG_EXT) rd_val = ext_ff;
        else if (araddr == `REG_FLAGS) rd_val = {20'h0, flags_ff};
        else if (araddr == `REG_CTRL) rd_val = ctrl_ff;
        else if (araddr == `REG_STATUS) rd_val = {err_ff, 31'h0} | {27'h0, ctrl_ff[4:0]};
        else rd_ok = 1'b0;
    end

    always @(posedge clock) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= `RST_WORD;
            rresp_ff  <= `RESP_OKAY;
        end else if (rvalid_ff) begin
            if (rready) rvalid_ff <= 1'b0;
        end else if (arvalid) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_val;
            rresp_ff  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

endmodule // integer_bcd_arith_unit

`default_nettype wire

/* File: sim/arith_bus_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module arith_bus_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // write side
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    // read side
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_wr_ans; awvalid && awready && wvalid && wready |=> bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
    a_b_done: assert property (p_b_done) else $error("write answer stuck");
    property p_w_block; bvalid |-> !awready && !wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write taken early");
    property p_rd_ans; arvalid && arready |=> rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_done; rvalid && rready |=> !rvalid && arready; endproperty
    a_r_done: assert property (p_r_done) else $error("read answer stuck");
    property p_bad_rd;
        arvalid && arready && (araddr > 8'h18 || araddr[1:0] != 2'h0)
            |=> rresp == 2'h2 && rdata == 32'h0;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("bad read not refused");
endmodule // arith_bus_sva
bind integer_bcd_arith_unit arith_bus_sva u_sva (
    .clock, .rst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);
`default_nettype wire

/* File: sim/integer_bcd_arith_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "arith_defs.vh"
module integer_bcd_arith_unit_tb;
    localparam logic [7:0]  opa_at = `REG_OPA;
    localparam logic [7:0]  opb_at = `REG_OPB;
    localparam logic [7:0]  acc_at = `REG_ACC;
    localparam logic [7:0]  ext_at = `REG_EXT;
    localparam logic [7:0]  flg_at = `REG_FLAGS;
    localparam logic [7:0]  ctl_at = `REG_CTRL;
    localparam logic [7:0]  sts_at = `REG_STATUS;
    localparam logic [31:0] all    = 32'hFFFFFFFF;
    localparam logic [31:0] w16    = 32'hFFFF;
    localparam logic [31:0] nil    = 32'h0;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rd_v;
    logic [3:0]  wstrb;
    logic [1:0]  rsp;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          failures, n_checks, slow;

    integer_bcd_arith_unit dut (
        .clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready
    );

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            failures++;
        end
    endtask

    // bready raised after slow+1 edges to exercise the hold
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (i == slow) bready <= 1'b1;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rsp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        failures++;
        stop_test();
    endtask

    task automatic rd(input logic [7:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (i == slow) rready <= 1'b1;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd_v = rdata;
                rsp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        failures++;
        stop_test();
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = all);
        rd(a);
        chk(rd_v & m, e);
    endtask

    // c holds the control word: [12] source width, [9:8] width, [4:0] operation
    task automatic run(input logic [15:0] c, input logic [31:0] a, b, acc, ext, fl,
                       input logic [7:0] ra, input logic [31:0] e, input logic [31:0] m = all);
        wr(flg_at, fl);
        wr(opa_at, a);
        wr(opb_at, b);
        wr(acc_at, acc);
        wr(ext_at, ext);
        wr(ctl_at, {16'h0, c});
        rc(ra, e, m);
    endtask

    task automatic t_bus();
        int k;
        for (k = 0; k < 7; k++) rc(8'(k * 4), nil);
        rd(8'h1C);
        chk({30'h0, rsp}, 32'h2);
        chk(rd_v, nil);
        wr(8'h06, all);
        chk({30'h0, rsp}, 32'h2);
        wr(sts_at, all);
        rc(sts_at, nil);
        slow = 3;
        wr(opb_at, 32'hA5);
        rc(opb_at, 32'hA5);
        slow = 0;
        $display("bus test done");
    endtask

    task automatic t_ext();
        run(16'h0014, nil, nil, 32'h8000, nil, nil, ext_at, w16, w16);
        run(16'h0014, nil, nil, 32'h7FFF, w16, nil, ext_at, nil, w16);
        run(16'h0015, nil, nil, 32'h80000000, nil, nil, ext_at, all);
        run(16'h0013, nil, nil, 32'h1280, nil, nil, acc_at, 32'hFF80, w16);
        run(16'h0216, nil, 32'h8081, nil, nil, nil, opa_at, 32'hFFFFFF81);
        run(16'h1216, nil, 32'h8081, nil, nil, nil, opa_at, 32'hFFFF8081);
        run(16'h0116, 32'hAAAA0000, 32'h81, nil, nil, nil, opa_at, 32'hAAAAFF81);
        run(16'h1217, all, 32'h8081, nil, nil, nil, opa_at, 32'h8081);
        $display("extend test done");
    endtask

    task automatic t_arith();
        run(16'h0000, 32'hFF, 32'h1, nil, nil, nil, flg_at, 32'h55);
        run(16'h0000, 32'h7F, 32'h1, nil, nil, nil, flg_at, 32'h890);
        rc(opa_at, 32'h80);
        run(16'h0201, 32'h1, 32'h1, nil, nil, 32'h1, opa_at, 32'h3);
        rc(flg_at, 32'h4);
        run(16'h0200, 32'h1, 32'h1, nil, nil, 32'h1, opa_at, 32'h2);
        run(16'h0202, 32'h3, 32'h3, nil, nil, nil, flg_at, 32'h44);
        run(16'h0203, 32'h5, 32'h2, nil, nil, 32'h1, opa_at, 32'h2);
        run(16'h0202, 32'h5, 32'h2, nil, nil, 32'h1, opa_at, 32'h3);
        run(16'h0106, 32'h1234, 32'h1234, nil, nil, 32'h891, flg_at, 32'h44);
        rc(opa_at, 32'h1234);
        rc(opb_at, 32'h1234);
        run(16'h0204, all, nil, nil, nil, 32'h1, flg_at, 32'h55);
        run(16'h0005, 32'h100, nil, nil, nil, nil, opa_at, 32'h1FF);
        rc(flg_at, 32'h94);
        run(16'h0107, 32'h1, nil, nil, nil, nil, opa_at, w16);
        rc(flg_at, 32'h95);
        $display("arith test done");
    endtask

    task automatic t_muldiv();
        run(16'h0008, nil, 32'hFF, 32'hFF, nil, nil, acc_at, 32'hFE01);
        rc(flg_at, 32'h801);
        run(16'h0208, nil, 32'h10000, 32'h10000, nil, nil, ext_at, 32'h1);
        run(16'h0109, nil, 32'h2, w16, nil, nil, acc_at, 32'hFFFE, w16);
        rc(ext_at, w16, w16);
        rc(flg_at, nil);
        run(16'h020A, 32'h3, 32'hFFFFFFFE, 32'h3, nil, nil, opa_at, 32'hFFFFFFFA);
        run(16'h000B, nil, 32'h7, 32'h64, nil, nil, acc_at, 32'h020E, w16);
        run(16'h010C, nil, 32'h2, 32'hFFF9, w16, nil, acc_at, 32'hFFFD, w16);
        rc(ext_at, w16, w16);
        run(16'h000C, nil, 32'hFE, 32'h7, nil, nil, acc_at, 32'h01FD);
        run(16'h020B, nil, nil, 32'h55, nil, nil, acc_at, 32'h55);
        rc(sts_at, 32'h8000000B);
        $display("muldiv test done");
    endtask

    task automatic t_bcd();
        run(16'h000D, nil, nil, 32'hAE, nil, nil, acc_at, 32'h14);
        rc(flg_at, 32'h1, 32'h1);
        run(16'h000E, nil, nil, 32'hEE, nil, 32'h11, acc_at, 32'h88);
        rc(flg_at, 32'h1, 32'h1);
        run(16'h000F, nil, nil, 32'h010D, nil, nil, acc_at, 32'h0203, w16);
        rc(flg_at, 32'h1, 32'h1);
        run(16'h0010, nil, nil, 32'h02FE, nil, nil, acc_at, 32'h0108, w16);
        rc(flg_at, 32'h1, 32'h1);
        run(16'h0011, nil, nil, 32'h3F, nil, nil, acc_at, 32'h0603, w16);
        run(16'h0012, nil, nil, 32'h0603, nil, nil, acc_at, 32'h3F, 32'hFF);
        $display("decimal test done");
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        slow = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_bus();
        t_ext();
        t_arith();
        t_muldiv();
        t_bcd();
        stop_test();
    end
endmodule // integer_bcd_arith_unit_tb
`default_nettype wire
